// File: verilog/lsc_pkg.sv
// Shared constants and types for the local scan chain configuration block
package lsc_pkg;
  // Build selection: silicon build has three ports and no secondary register
  localparam bit SILICON_BUILD = 1'b0;
  localparam bit FIVE_PORT_OPTION = 1'b1;
  localparam bit SECONDARY_PRESENT = !SILICON_BUILD;
  localparam int NUM_PORTS = 8;
  localparam logic [7:0] PORT_MASK = SILICON_BUILD ? 8'h07 : (SECONDARY_PRESENT ? 8'hFF : 8'h1F);

  // Register reset values
  localparam logic [7:0] PRIMARY_RESET = 8'h01;
  localparam logic [7:0] SECONDARY_RESET = 8'h00;
  localparam logic [7:0] GPIO_RESET = 8'h00;

  // Primary mode register fields
  localparam int BIT_PORT0 = 0;
  localparam int BIT_PORT1 = 1;
  localparam int BIT_PORT2 = 2;
  localparam int BIT_CLK_STOP = 3;
  localparam int BIT_LOOPBACK = 4;
  localparam int BIT_PORT3 = 5;
  localparam int BIT_PORT4 = 6;
  localparam int BIT_CNT_STATUS = 7;
  // Secondary mode register fields
  localparam int BIT_PORT5 = 0;
  localparam int BIT_PORT6 = 1;
  localparam int BIT_PORT7 = 2;

  // Parked-in-reset clock gating count, in backplane clock pulses
  localparam logic [9:0] PARK_RESET_PULSES = 10'h200;

  // Capture stream buffering
  localparam int CAP_WIDTH = 8;
  localparam int CAP_DEPTH = 32;

  typedef enum logic [2:0] {
    LSC_UNPARKED,
    LSC_PARKED_IN_RESET,
    LSC_PARKED_IN_IDLE,
    LSC_PARKED_IN_PAUSE_DR,
    LSC_PARKED_IN_PAUSE_IR
  } lsc_park_t;

  typedef enum logic [1:0] {
    LSC_DR_OTHER,
    LSC_DR_PRIMARY,
    LSC_DR_SECONDARY,
    LSC_DR_GPIO
  } lsc_dr_sel_t;

  typedef struct packed {
    logic tlr_entry;
    logic capture;
    logic shift;
    logic update;
  } lsc_tap_ctrl_t;

  typedef struct packed {
    logic on;
    logic zero;
    logic reload;
  } lsc_cnt_t;
endpackage

// File: verilog/lsc_chain_config.sv
// Local scan port network configuration with capture stream buffering
//
// Behaviour
// R01: Unparked path: input, bridge register, selected ports ascending, each with pad, output.
// R02: Extended build: secondary bits 0-2 select ports 5-7, after primary ports.
// R03: Primary bit 4 loops input through selected register to output, ignoring selects.
// R04: Parked with bit 3 set stops local clocks; unparked clocks always run.
// R05: Bit 3 clear keeps clocks running when parked in idle or pause.
// R06: Parked in reset gates local clock after 512 backplane pulses, ignoring bit 3.
// R07: Status bit 7 set only while counter enabled and at zero.
// R08: Status bit 7 cleared when counter is reloaded after counter select; the code keeps it set if reload comes with counter on and at zero.
// R09: Status bit 7 is zero after power-on.
// R10: Secondary register exists only in the configurable build.
// R11: Silicon build has three ports selected by primary bits 0-2.
// R12: Configurable build may use primary bits 5 and 6 for ports 3 and 4.
// R13: Test-logic-reset entry loads primary register with 00000001; the code loads 10000001 if the counter is on and at zero in that cycle.
// R14: Counter enabled and port parked: stop and hold local clocks at terminal count; parked in reset, the code ignores the counter.
// R15: Each pad stage is one backplane-clocked flip-flop retiming port output.
`timescale 1ns/100ps

module lsc_fifo #(
  parameter int WIDTH = lsc_pkg::CAP_WIDTH,
  parameter int DEPTH = lsc_pkg::CAP_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (in_valid && !full)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid && !full)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

module lsc_chain_config (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Backplane test clock and serial data
  input wire logic tck_b,
  input wire logic tdi_b,
  output logic tdo_b,
  // Bridge controller state on the backplane clock
  input wire lsc_pkg::lsc_tap_ctrl_t tap,
  input wire lsc_pkg::lsc_dr_sel_t dr_sel,
  input wire logic other_reg_tdo,
  input wire lsc_pkg::lsc_park_t park_state,
  input wire lsc_pkg::lsc_cnt_t tck_cnt,
  // Local scan ports, GPIO select and capture overrun flag
  output logic [lsc_pkg::NUM_PORTS-1:0] lsp_tdi,
  input wire logic [lsc_pkg::NUM_PORTS-1:0] lsp_tdo,
  output logic lsp_clk_run,
  output logic [7:0] gpio_select,
  output logic cap_overrun,
  // Captured backplane output stream, system clock
  output logic cap_valid,
  input wire logic cap_ready,
  output logic [lsc_pkg::CAP_WIDTH-1:0] cap_data
);
  logic [7:0] scan_port_mode_primary;
  // Select and loopback bits and the read-only status bit have separate drivers
  logic [6:0] primary_cfg;
  logic cnt_status;
  logic [7:0] scan_port_mode_secondary;
  logic [7:0] scan_port_gpio_select;
  logic [7:0] dr_shift;
  logic head_bit;
  logic parked;
  logic [lsc_pkg::NUM_PORTS-1:0] port_en;
  logic [lsc_pkg::NUM_PORTS:0] stage;
  logic [lsc_pkg::NUM_PORTS-1:0] pad;
  logic [9:0] park_reset_cnt;
  logic [lsc_pkg::CAP_WIDTH-1:0] pack_shift;
  logic [lsc_pkg::CAP_WIDTH-1:0] pack_word;
  logic [2:0] pack_cnt;
  logic req_tgl;
  logic ack_s1;
  logic ack_s2;
  logic req_s1;
  logic req_s2;
  logic ack_tgl;
  logic push_valid;
  logic push_ready;

  // R02 R11 R12: port order and build limits
  // Maps both mode registers onto port index order, limited to the build
  function automatic logic [7:0] port_select(input logic [7:0] pri, input logic [7:0] sec);
    logic [7:0] sel;
    sel = 8'h00;
    sel[0] = pri[lsc_pkg::BIT_PORT0];
    sel[1] = pri[lsc_pkg::BIT_PORT1];
    sel[2] = pri[lsc_pkg::BIT_PORT2];
    sel[3] = pri[lsc_pkg::BIT_PORT3] & lsc_pkg::FIVE_PORT_OPTION;
    sel[4] = pri[lsc_pkg::BIT_PORT4] & lsc_pkg::FIVE_PORT_OPTION;
    sel[5] = sec[lsc_pkg::BIT_PORT5];
    sel[6] = sec[lsc_pkg::BIT_PORT6];
    sel[7] = sec[lsc_pkg::BIT_PORT7];
    return sel & lsc_pkg::PORT_MASK;
  endfunction

  assign parked = (park_state != lsc_pkg::LSC_UNPARKED);
  // R03: loopback removes every port
  assign port_en = (parked || scan_port_mode_primary[lsc_pkg::BIT_LOOPBACK]) ? 8'h00 :
                   port_select(scan_port_mode_primary, scan_port_mode_secondary);
  assign head_bit = (dr_sel == lsc_pkg::LSC_DR_OTHER) ? other_reg_tdo : dr_shift[0];
  assign gpio_select = scan_port_gpio_select;
  assign scan_port_mode_primary = {cnt_status, primary_cfg};

  // Shared shift stage for the two mode registers and the GPIO select register
  always_ff @(posedge tck_b or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dr_shift <= 8'h00;
    end
    else if (tap.capture)
    begin
      case (dr_sel)
        lsc_pkg::LSC_DR_PRIMARY: dr_shift <= scan_port_mode_primary;
        lsc_pkg::LSC_DR_SECONDARY: dr_shift <= scan_port_mode_secondary;
        lsc_pkg::LSC_DR_GPIO: dr_shift <= scan_port_gpio_select;
        default: dr_shift <= dr_shift;
      endcase
    end
    else if (tap.shift)
    begin
      dr_shift <= {tdi_b, dr_shift[7:1]};
    end
  end

  // Configuration bits of the primary register; bit 7 is kept apart
  always_ff @(posedge tck_b or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_cfg <= lsc_pkg::PRIMARY_RESET[6:0];
    end
    // R13: reset state entry selects port 0 only
    else if (tap.tlr_entry)
    begin
      primary_cfg <= lsc_pkg::PRIMARY_RESET[6:0];
    end
    else if (tap.update && dr_sel == lsc_pkg::LSC_DR_PRIMARY)
    begin
      primary_cfg <= dr_shift[6:0];
    end
  end

  // Counter status is read only; a set in the reload cycle wins
  always_ff @(posedge tck_b or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // R09: power-on zero
      cnt_status <= 1'b0;
    end
    // R07: set at terminal count with counter on
    else if (tck_cnt.on && tck_cnt.zero)
    begin
      cnt_status <= 1'b1;
    end
    // R08: cleared on reload
    else if (tck_cnt.reload || tap.tlr_entry)
    begin
      cnt_status <= 1'b0;
    end
  end

  // R10: secondary register only in the configurable build
  generate
    if (lsc_pkg::SECONDARY_PRESENT)
    begin : g_secondary
      always_ff @(posedge tck_b or negedge rst_n)
      begin
        if (!rst_n)
        begin
          scan_port_mode_secondary <= lsc_pkg::SECONDARY_RESET;
        end
        else if (tap.tlr_entry)
        begin
          scan_port_mode_secondary <= lsc_pkg::SECONDARY_RESET;
        end
        else if (tap.update && dr_sel == lsc_pkg::LSC_DR_SECONDARY)
        begin
          scan_port_mode_secondary <= dr_shift;
        end
      end
    end
    else
    begin : g_no_secondary
      assign scan_port_mode_secondary = 8'h00;
    end
  endgenerate

  always_ff @(posedge tck_b or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scan_port_gpio_select <= lsc_pkg::GPIO_RESET;
    end
    else if (tap.tlr_entry)
    begin
      scan_port_gpio_select <= lsc_pkg::GPIO_RESET;
    end
    else if (tap.update && dr_sel == lsc_pkg::LSC_DR_GPIO)
    begin
      scan_port_gpio_select <= dr_shift;
    end
  end

  // R01: ascending chain, skipped ports pass the stage straight through
  assign stage[0] = head_bit;
  generate
    for (genvar i = 0; i < lsc_pkg::NUM_PORTS; i++)
    begin : g_port
      assign stage[i+1] = port_en[i] ? pad[i] : stage[i];
      // R15: one retiming flop per port
      always_ff @(posedge tck_b or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pad[i] <= 1'b0;
          lsp_tdi[i] <= 1'b0;
        end
        else
        begin
          pad[i] <= lsp_tdo[i];
          lsp_tdi[i] <= stage[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge tck_b or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo_b <= 1'b0;
    end
    else
    begin
      tdo_b <= stage[lsc_pkg::NUM_PORTS];
    end
  end

  // R06: pulses counted only while parked in reset, saturating
  always_ff @(posedge tck_b or negedge rst_n)
  begin
    if (!rst_n)
    begin
      park_reset_cnt <= 10'h000;
    end
    else if (park_state != lsc_pkg::LSC_PARKED_IN_RESET)
    begin
      park_reset_cnt <= 10'h000;
    end
    else if (park_reset_cnt != lsc_pkg::PARK_RESET_PULSES)
    begin
      park_reset_cnt <= park_reset_cnt + 10'h001;
    end
  end

  always_ff @(posedge tck_b or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lsp_clk_run <= 1'b1;
    end
    else
    begin
      case (park_state)
        lsc_pkg::LSC_UNPARKED: lsp_clk_run <= 1'b1;
        // R06: gated after the pulse count, bit 3 ignored
        lsc_pkg::LSC_PARKED_IN_RESET: lsp_clk_run <= (park_reset_cnt != lsc_pkg::PARK_RESET_PULSES);
        // R04 R05 R14: bit 3 or terminal count stops clocks
        default: lsp_clk_run <= !scan_port_mode_primary[lsc_pkg::BIT_CLK_STOP] && !(tck_cnt.on && tck_cnt.zero);
      endcase
    end
  end

  // Packs the backplane output stream into words during shifting
  always_ff @(posedge tck_b or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pack_shift <= '0;
      pack_cnt <= 3'h0;
      pack_word <= '0;
      req_tgl <= 1'b0;
      cap_overrun <= 1'b0;
    end
    else if (tap.tlr_entry)
    begin
      pack_cnt <= 3'h0;
      cap_overrun <= 1'b0;
    end
    else if (tap.shift)
    begin
      pack_shift <= {stage[lsc_pkg::NUM_PORTS], pack_shift[lsc_pkg::CAP_WIDTH-1:1]};
      pack_cnt <= pack_cnt + 3'h1;
      // Scan clock cannot stall, so a word finished while the last is unacknowledged is lost
      if (pack_cnt == 3'h7 && req_tgl != ack_s2)
      begin
        cap_overrun <= 1'b1;
      end
      else if (pack_cnt == 3'h7)
      begin
        pack_word <= {stage[lsc_pkg::NUM_PORTS], pack_shift[lsc_pkg::CAP_WIDTH-1:1]};
        req_tgl <= !req_tgl;
      end
    end
  end

  always_ff @(posedge tck_b or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end
    else
    begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // System side: word is stable from request toggle until acknowledge returns
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      ack_tgl <= 1'b0;
    end
    else
    begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      if (push_valid && push_ready)
      begin
        ack_tgl <= req_s2;
      end
    end
  end

  assign push_valid = (req_s2 != ack_tgl);

  lsc_fifo #(
    .WIDTH(lsc_pkg::CAP_WIDTH),
    .DEPTH(lsc_pkg::CAP_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(pack_word),
    .out_valid(cap_valid),
    .out_ready(cap_ready),
    .out_data(cap_data)
  );

  // R13: reset entry reloads the select field
  a_tlr_reload: assert property (@(posedge tck_b) disable iff (!rst_n)
    tap.tlr_entry |=> scan_port_mode_primary[6:0] == 7'h01) else $error("primary not reloaded");
  // R07: terminal count sets status
  a_status_set: assert property (@(posedge tck_b) disable iff (!rst_n)
    tck_cnt.on && tck_cnt.zero |=> scan_port_mode_primary[7]) else $error("status not set");
  // R08: reload clears status
  a_status_clear: assert property (@(posedge tck_b) disable iff (!rst_n)
    tck_cnt.reload && !(tck_cnt.on && tck_cnt.zero) |=> !scan_port_mode_primary[7]) else $error("status not cleared");
  // R03: loopback path
  a_loopback_path: assert property (@(posedge tck_b) disable iff (!rst_n)
    scan_port_mode_primary[4] |=> tdo_b == $past(head_bit)) else $error("loopback broken");
  // R04: bit 3 stops parked clocks
  a_parked_stop: assert property (@(posedge tck_b) disable iff (!rst_n)
    parked && park_state != lsc_pkg::LSC_PARKED_IN_RESET && scan_port_mode_primary[3] |=> !lsp_clk_run)
    else $error("parked clock not stopped");
  // R05: idle with bit 3 clear runs
  a_idle_running: assert property (@(posedge tck_b) disable iff (!rst_n)
    park_state == lsc_pkg::LSC_PARKED_IN_IDLE && !scan_port_mode_primary[3] && !tck_cnt.on |=> lsp_clk_run)
    else $error("idle clock stopped");
  // R04: unparked always runs
  a_unparked_run: assert property (@(posedge tck_b) disable iff (!rst_n)
    !parked |=> lsp_clk_run) else $error("unparked clock stopped");
  // R06: gating at the pulse count
  a_reset_gate: assert property (@(posedge tck_b) disable iff (!rst_n)
    park_state == lsc_pkg::LSC_PARKED_IN_RESET && park_reset_cnt == 10'h200 |=> !lsp_clk_run)
    else $error("reset park clock not gated");
  // R15: port 0 output reaches the backplane output two flops later
  a_pad_retime: assert property (@(posedge tck_b) disable iff (!rst_n)
    (port_en == 8'h01) [*2] |=> tdo_b == $past(lsp_tdo[0], 2)) else $error("pad stage timing");
  // R11: no port outside the build is ever inserted
  a_build_ports: assert property (@(posedge tck_b) disable iff (!rst_n)
    (port_en & ~lsc_pkg::PORT_MASK) == 8'h00) else $error("port outside build");
  // R02: secondary selects port 5
  a_secondary_sel: assert property (@(posedge tck_b) disable iff (!rst_n)
    !parked && !scan_port_mode_primary[4] |-> port_en[5] == scan_port_mode_secondary[0])
    else $error("secondary select mismatch");

  c_loopback: cover property (@(posedge tck_b) disable iff (!rst_n) scan_port_mode_primary[4] && !parked);
  c_three_ports: cover property (@(posedge tck_b) disable iff (!rst_n) port_en[2:0] == 3'h7);
  c_fifo_full: cover property (@(posedge clk) disable iff (!rst_n) push_valid && !push_ready);
  c_status: cover property (@(posedge tck_b) disable iff (!rst_n) $rose(scan_port_mode_primary[7]));
endmodule

// File: tb/lsc_port_model.sv
// Behavioural local scan ports, one bypass stage per port on the gated local clock
`timescale 1ns/100ps
module lsc_port_model (
  // Backplane clock and reset
  input wire logic tck_b,
  input wire logic rst_n,
  // Local port side of the bridge
  input wire logic lsp_clk_run,
  input wire logic [lsc_pkg::NUM_PORTS-1:0] lsp_tdi,
  output logic [lsc_pkg::NUM_PORTS-1:0] lsp_tdo
);
  always_ff @(posedge tck_b or negedge rst_n)
  begin
    if (!rst_n)
      lsp_tdo <= '0;
    else if (lsp_clk_run)
      lsp_tdo <= lsp_tdi;
  end
endmodule

// File: tb/tb.sv
// Self-checking bench for the local scan chain configuration block
`timescale 1ns/100ps
`define CHK(act, exp, msg) begin checks_done++; if ((act) !== (exp)) begin fail_count++; $display("mismatch at %0t: %s", $time, msg); end end
module tb;
  logic clk = 1'b0;
  logic tck_b = 1'b0;
  logic rst_n = 1'b0;
  logic tdi_b = 1'b0;
  logic tdo_b;
  lsc_pkg::lsc_tap_ctrl_t tap = '0;
  lsc_pkg::lsc_dr_sel_t dr_sel = lsc_pkg::LSC_DR_OTHER;
  logic other_reg_tdo = 1'b0;
  lsc_pkg::lsc_park_t park_state = lsc_pkg::LSC_PARKED_IN_IDLE;
  lsc_pkg::lsc_cnt_t tck_cnt = '0;
  logic [lsc_pkg::NUM_PORTS-1:0] lsp_tdi;
  logic [lsc_pkg::NUM_PORTS-1:0] lsp_tdo;
  logic lsp_clk_run;
  logic [7:0] gpio_select;
  logic cap_overrun;
  logic cap_valid;
  logic cap_ready = 1'b1;
  logic [lsc_pkg::CAP_WIDTH-1:0] cap_data;
  logic [7:0] last_word = 8'h00;
  logic [7:0] rd;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int words = 0;
  logic [7:0] cp [6] = '{8'h00, 8'h01, 8'h05, 8'h60, 8'h67, 8'h17};
  logic [7:0] cs [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h07};
  int cn [6] = '{0, 1, 2, 2, 8, 0};

  always #4 clk = ~clk;
  always #32 tck_b = ~tck_b;

  lsc_chain_config lsc_chain_config_inst (.clk(clk), .rst_n(rst_n), .tck_b(tck_b), .tdi_b(tdi_b), .tdo_b(tdo_b),
    .tap(tap), .dr_sel(dr_sel), .other_reg_tdo(other_reg_tdo), .park_state(park_state), .tck_cnt(tck_cnt),
    .lsp_tdi(lsp_tdi), .lsp_tdo(lsp_tdo), .lsp_clk_run(lsp_clk_run), .gpio_select(gpio_select),
    .cap_overrun(cap_overrun), .cap_valid(cap_valid), .cap_ready(cap_ready), .cap_data(cap_data));

  lsc_port_model lsc_port_model_inst (.tck_b(tck_b), .rst_n(rst_n), .lsp_clk_run(lsp_clk_run),
    .lsp_tdi(lsp_tdi), .lsp_tdo(lsp_tdo));

  task automatic summarize();
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge tck_b);
  endtask

  // Capture, eight shifts LSB first, update; returns what left on the backplane output
  task automatic scan(input lsc_pkg::lsc_dr_sel_t sel, input logic [7:0] wr, output logic [7:0] got);
    @(posedge tck_b);
    dr_sel <= sel;
    tap <= 4'h4;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge tck_b);
      tap <= 4'h2;
      tdi_b <= wr[i];
      if (i > 0)
      begin
        @(negedge tck_b);
        got[i-1] = tdo_b;
      end
    end
    @(posedge tck_b);
    tap <= 4'h1;
    @(negedge tck_b);
    got[7] = tdo_b;
    @(posedge tck_b);
    tap <= 4'h0;
  endtask

  // Measures edges from a falling edge at the chain head to the backplane output
  task automatic chain(input logic [7:0] prim, input logic [7:0] sec, input int n);
    int lat;
    logic [7:0] junk;
    scan(lsc_pkg::LSC_DR_SECONDARY, sec, junk);
    scan(lsc_pkg::LSC_DR_PRIMARY, prim, junk);
    @(posedge tck_b);
    park_state <= lsc_pkg::LSC_UNPARKED;
    dr_sel <= lsc_pkg::LSC_DR_OTHER;
    tap <= 4'h2;
    other_reg_tdo <= 1'b1;
    tick(40);
    other_reg_tdo <= 1'b0;
    lat = 0;
    while (lat < 40)
    begin
      @(posedge tck_b);
      lat++;
      @(negedge tck_b);
      if (tdo_b === 1'b0)
        break;
    end
    `CHK(lat, 1 + 3 * n, "chain length")
    @(posedge tck_b);
    tap <= 4'h0;
    park_state <= lsc_pkg::LSC_PARKED_IN_IDLE;
  endtask

  always @(posedge clk)
  begin
    if (cap_valid === 1'b1 && cap_ready)
    begin
      words++;
      last_word = cap_data;
    end
  end

  // Ceiling well above the roughly 11400 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      $display("mismatch at %0t: timeout", $time);
      summarize();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    @(posedge clk);
    cap_ready <= 1'b0;
    @(posedge tck_b);
    other_reg_tdo <= 1'b1;
    tap <= 4'h2;
    tick(34 * 8);
    tap <= 4'h0;
    tick(4);
    `CHK(cap_overrun, 1'b1, "overrun after full buffer")
    `CHK(words, 0, "words taken while stalled")
    @(posedge clk);
    cap_ready <= 1'b1;
    repeat (300) @(posedge clk);
    `CHK(words, 33, "drained word count")
    `CHK(last_word, 8'hFF, "drained word data")
    @(posedge tck_b);
    other_reg_tdo <= 1'b0;
    scan(lsc_pkg::LSC_DR_PRIMARY, 8'h01, rd);
    `CHK(rd, 8'h01, "primary reset value")
    scan(lsc_pkg::LSC_DR_SECONDARY, 8'h00, rd);
    `CHK(rd, 8'h00, "secondary reset value")
    scan(lsc_pkg::LSC_DR_GPIO, 8'hA5, rd);
    `CHK(rd, 8'h00, "gpio reset value")
    tick(1);
    `CHK(gpio_select, 8'hA5, "gpio written")
    scan(lsc_pkg::LSC_DR_PRIMARY, 8'hFF, rd);
    scan(lsc_pkg::LSC_DR_PRIMARY, 8'h00, rd);
    `CHK(rd, 8'h7F, "status bit not writable")
    scan(lsc_pkg::LSC_DR_OTHER, 8'h5A, rd);
    scan(lsc_pkg::LSC_DR_PRIMARY, 8'h07, rd);
    `CHK(rd, 8'h00, "update of other register ignored")
    @(posedge tck_b);
    tap <= 4'h8;
    @(posedge tck_b);
    tap <= 4'h0;
    tick(1);
    `CHK(cap_overrun, 1'b0, "overrun cleared by reset entry")
    scan(lsc_pkg::LSC_DR_PRIMARY, 8'h09, rd);
    `CHK(rd, 8'h01, "reload on reset entry")
    tick(2);
    `CHK(lsp_clk_run, 1'b0, "parked with stop bit")
    park_state <= lsc_pkg::LSC_UNPARKED;
    tick(2);
    `CHK(lsp_clk_run, 1'b1, "unparked runs")
    scan(lsc_pkg::LSC_DR_PRIMARY, 8'h01, rd);
    for (int p = 0; p < 3; p++)
    begin
      park_state <= lsc_pkg::lsc_park_t'(2 + p);
      tick(2);
      `CHK(lsp_clk_run, 1'b1, "parked idle or pause runs")
    end
    park_state <= lsc_pkg::LSC_PARKED_IN_IDLE;
    tck_cnt <= 3'b110;
    tick(2);
    `CHK(lsp_clk_run, 1'b0, "terminal count stops clock")
    scan(lsc_pkg::LSC_DR_PRIMARY, 8'h01, rd);
    `CHK(rd, 8'h81, "status set at terminal count")
    tck_cnt <= 3'b101;
    tick(1);
    tck_cnt <= 3'b000;
    tick(2);
    `CHK(lsp_clk_run, 1'b1, "counter off runs")
    tck_cnt <= 3'b010;
    scan(lsc_pkg::LSC_DR_PRIMARY, 8'h01, rd);
    `CHK(rd, 8'h01, "status cleared by reload")
    scan(lsc_pkg::LSC_DR_PRIMARY, 8'h01, rd);
    `CHK(rd, 8'h01, "status stays clear with counter off")
    tck_cnt <= 3'b000;
    park_state <= lsc_pkg::LSC_PARKED_IN_RESET;
    tick(500);
    `CHK(lsp_clk_run, 1'b1, "reset park before count")
    tick(20);
    `CHK(lsp_clk_run, 1'b0, "reset park after count")
    park_state <= lsc_pkg::LSC_PARKED_IN_IDLE;
    for (int c = 0; c < 6; c++)
      chain(cp[c], cs[c], cn[c]);
    summarize();
  end
endmodule
